// ### logic/dcpt_pkg.sv
// shared constants for the channel progress tracking block
package dcpt_pkg;
   localparam int          DATA_W        = 16;
   localparam int          ADDR_W        = 8;
   localparam int          NUM_REGS      = 8;
   // register byte offsets
   localparam logic [7:0]  OFS_SRC_LEN   = 8'h00;
   localparam logic [7:0]  OFS_DST_LEN   = 8'h04;
   localparam logic [7:0]  OFS_SRC_PTR   = 8'h08;
   localparam logic [7:0]  OFS_DST_PTR   = 8'h0C;
   localparam logic [7:0]  OFS_CELL_SIZE = 8'h10;
   localparam logic [7:0]  OFS_CELL_PROG = 8'h14;
   localparam logic [7:0]  OFS_MATCH     = 8'h18;
   localparam logic [7:0]  OFS_CTRL      = 8'h1C;
   // control register fields
   localparam int          CTRL_EN_BIT   = 0;
   localparam int          CTRL_PAT_BIT  = 1;
   localparam int          CTRL_BUSY_BIT = 4;
   // reset values
   localparam logic [15:0] RST_WORD      = 16'h0000;
   // a zero size field means one more than the field can hold
   localparam logic [16:0] FULL_SPAN     = 17'h10000;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_MOVE = 2'b10
   } dcpt_state_t;
endpackage

// ### logic/dcpt_apb_slave.sv
// apb slave: address decode, read data flop, ready and error
`timescale 1ns/1ps
module dcpt_apb_slave (
   input  wire logic                          clk,
   input  wire logic                          rstN,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [dcpt_pkg::ADDR_W-1:0]   paddr,
   input  wire logic [dcpt_pkg::DATA_W-1:0]   regWords [dcpt_pkg::NUM_REGS],
   output logic      [31:0]                   prdata,
   output logic                               pready,
   output logic                               pslverr,
   output logic                               wrStrobe,
   output logic      [2:0]                    wrIdx
);
   import dcpt_pkg::*;

   logic        hit;
   logic [31:0] prdata_q;

   // word aligned and inside the eight-word window
   assign hit   = (paddr[7:5] == 3'h0) && (paddr[1:0] == 2'h0);
   assign wrIdx = paddr[4:2];

   // data is latched in the setup cycle so the access phase is one cycle
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         prdata_q <= 32'h00000000;
      end else if (psel && !penable) begin
         prdata_q <= hit ? {16'h0000, regWords[wrIdx]} : 32'h00000000;
      end
   end

   // every access completes in its first access cycle
   assign prdata   = prdata_q;
   assign pready   = psel && penable;
   assign pslverr  = pready && !hit;
   assign wrStrobe = pready && pwrite && hit;
endmodule

// ### logic/dcpt_channel.sv
// one dma channel: byte pointers, cell progress and pattern terminate
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/1ps
// How it works
// - source byte index is 16-bit read-only, counting source bytes reached.
// - a pattern detect in pattern mode clears the source byte index.
// - destination byte index is 16-bit read-only, counting bytes reached.
// - each accepted trigger moves bytes_per_event bytes unless a pattern detect ends it first; zero means 65,536 bytes.
// - event progress counts bytes moved since the last trigger.
// - progress count wraps to zero once a full cell has moved, so it reads zero in idle.
// - a pattern detect in pattern mode clears the progress count.
// - in pattern mode a matching data byte ends the channel transfer.
// - upper sixteen bits of all these registers read as zero.
// - source buffer length is 16-bit; zero means 65,536 bytes.
module dcpt_channel (
   input  wire logic                          clk,
   input  wire logic                          reset_n,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [dcpt_pkg::ADDR_W-1:0]   paddr,
   input  wire logic [31:0]                   pwdata,
   output logic      [31:0]                   prdata,
   output logic                               pready,
   output logic                               pslverr,
   input  wire logic                          cellTrig,
   output logic                               busReq,
   input  wire logic                          busAck,
   input  wire logic [7:0]                    busData,
   output logic      [dcpt_pkg::DATA_W-1:0]   srcIndex,
   output logic      [dcpt_pkg::DATA_W-1:0]   dstIndex,
   output logic                               cellDone,
   output logic                               xferDone
);
   import dcpt_pkg::*;

   logic              rstMeta_q;
   logic              rstN_q;
   dcpt_state_t       state_q;
   logic [15:0]       srcLen_q;
   logic [15:0]       dstLen_q;
   logic [15:0]       srcPtr_q;
   logic [15:0]       dstPtr_q;
   logic [15:0]       cellSize_q;
   logic [15:0]       cellCnt_q;
   logic [15:0]       match_q;
   logic              enable_q;
   logic              patMode_q;
   logic              cellDone_q;
   logic              xferDone_q;
   logic              wrStrobe;
   logic [2:0]        wrIdx;
   logic [15:0]       regWords [NUM_REGS];
   logic              moving;
   logic              detect;
   logic              cellEnd;
   logic              srcWrap;
   logic              dstWrap;
   logic [16:0]       cellSpan;
   logic [16:0]       srcSpan;
   logic [16:0]       dstSpan;
   logic [16:0]       cellNext;
   logic [16:0]       srcNext;
   logic [16:0]       dstNext;
   logic [15:0]       ctrlWord;

   // reset release through two flops; the first feeds only the second
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rstMeta_q <= 1'b0;
         rstN_q    <= 1'b0;
      end else begin
         rstMeta_q <= 1'b1;
         rstN_q    <= rstMeta_q;
      end
   end

   dcpt_apb_slave u_apb (
      .clk      (clk),
      .rstN     (rstN_q),
      .psel     (psel),
      .penable  (penable),
      .pwrite   (pwrite),
      .paddr    (paddr),
      .regWords (regWords),
      .prdata   (prdata),
      .pready   (pready),
      .pslverr  (pslverr),
      .wrStrobe (wrStrobe),
      .wrIdx    (wrIdx)
   );

   // read view; upper halves are zero-filled by the slave
   assign ctrlWord = {11'h000, (state_q == ST_MOVE), 2'h0,
                      patMode_q, enable_q};
   assign regWords[OFS_SRC_LEN[4:2]]   = srcLen_q;
   assign regWords[OFS_DST_LEN[4:2]]   = dstLen_q;
   assign regWords[OFS_SRC_PTR[4:2]]   = srcPtr_q;
   assign regWords[OFS_DST_PTR[4:2]]   = dstPtr_q;
   assign regWords[OFS_CELL_SIZE[4:2]] = cellSize_q;
   assign regWords[OFS_CELL_PROG[4:2]] = cellCnt_q;
   assign regWords[OFS_MATCH[4:2]]     = match_q;
   assign regWords[OFS_CTRL[4:2]]      = ctrlWord;

   // zero in a size field stands for the full 65,536-byte span
   assign cellSpan = (cellSize_q == 16'h0000) ? FULL_SPAN
                                             : {1'b0, cellSize_q};
   assign srcSpan  = (srcLen_q == 16'h0000) ? FULL_SPAN
                                           : {1'b0, srcLen_q};
   assign dstSpan  = (dstLen_q == 16'h0000) ? FULL_SPAN
                                           : {1'b0, dstLen_q};
   assign cellNext = {1'b0, cellCnt_q} + 17'h00001;
   assign srcNext  = {1'b0, srcPtr_q} + 17'h00001;
   assign dstNext  = {1'b0, dstPtr_q} + 17'h00001;

   // one byte moves per acknowledged request
   assign moving  = (state_q == ST_MOVE) && busAck;
   // match value only counts in pattern mode
   assign detect  = moving && patMode_q
                    && (busData == match_q[7:0]);
   assign cellEnd = moving && (cellNext == cellSpan);
   assign srcWrap = srcNext == srcSpan;
   assign dstWrap = dstNext == dstSpan;
   assign busReq  = (state_q == ST_MOVE);

   // channel sequencing; triggers while busy are dropped
   always_ff @(posedge clk or negedge rstN_q) begin
      if (!rstN_q) begin
         state_q <= ST_IDLE;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               if (cellTrig && enable_q) begin
                  state_q <= ST_MOVE;
               end
            end
            ST_MOVE: begin
               if (detect || cellEnd) begin
                  state_q <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // software-written configuration
   always_ff @(posedge clk or negedge rstN_q) begin
      if (!rstN_q) begin
         srcLen_q   <= RST_WORD;
         dstLen_q   <= RST_WORD;
         cellSize_q <= RST_WORD;
         match_q    <= RST_WORD;
         patMode_q  <= 1'b0;
      end else if (wrStrobe) begin
         unique case (wrIdx)
            OFS_SRC_LEN[4:2]:   srcLen_q   <= pwdata[15:0];
            OFS_DST_LEN[4:2]:   dstLen_q   <= pwdata[15:0];
            OFS_CELL_SIZE[4:2]: cellSize_q <= pwdata[15:0];
            OFS_MATCH[4:2]:     match_q    <= pwdata[15:0];
            OFS_CTRL[4:2]:      patMode_q  <= pwdata[CTRL_PAT_BIT];
            default:            patMode_q  <= patMode_q;   // pointers are RO
         endcase
      end
   end

   // enable: a termination beats a software write in the same cycle
   always_ff @(posedge clk or negedge rstN_q) begin
      if (!rstN_q) begin
         enable_q <= 1'b0;
      end else if (detect) begin
         enable_q <= 1'b0;
      end else if (wrStrobe && wrIdx == OFS_CTRL[4:2]) begin
         enable_q <= pwdata[CTRL_EN_BIT];
      end
   end

   // source index: advances per byte, wraps at buffer end
   always_ff @(posedge clk or negedge rstN_q) begin
      if (!rstN_q) begin
         srcPtr_q <= RST_WORD;
      end else if (detect) begin
         srcPtr_q <= 16'h0000;
      end else if (moving) begin
         srcPtr_q <= srcWrap ? 16'h0000 : srcNext[15:0];
      end
   end

   // destination index; a pattern detect does not clear it, the matching byte still advances it
   always_ff @(posedge clk or negedge rstN_q) begin
      if (!rstN_q) begin
         dstPtr_q <= RST_WORD;
      end else if (moving) begin
         dstPtr_q <= dstWrap ? 16'h0000 : dstNext[15:0];
      end
   end

   // cell progress; wraps to zero at cell end, so it always reads zero in idle
   always_ff @(posedge clk or negedge rstN_q) begin
      if (!rstN_q) begin
         cellCnt_q <= RST_WORD;
      end else if (detect || cellEnd) begin
         cellCnt_q <= 16'h0000;
      end else if (moving) begin
         cellCnt_q <= cellNext[15:0];
      end
   end

   // completion pulses, one cycle after the ending byte
   always_ff @(posedge clk or negedge rstN_q) begin
      if (!rstN_q) begin
         cellDone_q <= 1'b0;
         xferDone_q <= 1'b0;
      end else begin
         cellDone_q <= cellEnd && !detect;
         xferDone_q <= detect;
      end
   end

   assign srcIndex = srcPtr_q;
   assign dstIndex = dstPtr_q;
   assign cellDone = cellDone_q;
   assign xferDone = xferDone_q;

   src_clear_a: assert property (@(posedge clk) disable iff (!rstN_q)
      detect |=> srcPtr_q == 16'h0000)
      else $error("source index not cleared on pattern detect");

   cell_clear_a: assert property (@(posedge clk) disable iff (!rstN_q)
      detect |=> cellCnt_q == 16'h0000 && xferDone)
      else $error("progress not cleared on pattern detect");

   src_step_a: assert property (@(posedge clk) disable iff (!rstN_q)
      moving && !detect && !srcWrap |=> srcPtr_q == $past(srcPtr_q) + 16'h0001)
      else $error("source index did not advance by one");

   dst_step_a: assert property (@(posedge clk) disable iff (!rstN_q)
      moving && !dstWrap |=> dstPtr_q == $past(dstPtr_q) + 16'h0001)
      else $error("destination index did not advance by one");

   cell_size_a: assert property (@(posedge clk) disable iff (!rstN_q)
      $rose(cellDone) |-> {1'b0, $past(cellCnt_q)} + 17'h00001 == cellSpan)
      else $error("cell ended at wrong byte count");

   cell_wrap_a: assert property (@(posedge clk) disable iff (!rstN_q)
      cellEnd |=> cellCnt_q == 16'h0000 && state_q == ST_IDLE)
      else $error("progress did not wrap after a full cell");

   idle_zero_a: assert property (@(posedge clk) disable iff (!rstN_q)
      state_q == ST_IDLE |-> cellCnt_q == 16'h0000)
      else $error("progress nonzero while idle");

   stop_match_a: assert property (@(posedge clk) disable iff (!rstN_q)
      detect |=> !enable_q && !busReq)
      else $error("transfer not ended on match");

   read_upper_a: assert property (@(posedge clk) disable iff (!rstN_q)
      pready |-> prdata[31:16] == 16'h0000)
      else $error("upper read bits not zero");

   no_pattern_a: assert property (@(posedge clk) disable iff (!rstN_q)
      !patMode_q ##1 1'b1 |-> !xferDone)
      else $error("pattern ended a transfer outside pattern mode");

   src_hold_a: assert property (@(posedge clk) disable iff (!rstN_q)
      !moving |=> srcPtr_q == $past(srcPtr_q))
      else $error("source index moved without a byte");

   dst_hold_a: assert property (@(posedge clk) disable iff (!rstN_q)
      !moving |=> dstPtr_q == $past(dstPtr_q))
      else $error("destination index moved without a byte");

   src_wrap_a: assert property (@(posedge clk) disable iff (!rstN_q)
      moving && !detect && srcWrap |=> srcPtr_q == 16'h0000)
      else $error("source index did not wrap at buffer end");

   dst_wrap_a: assert property (@(posedge clk) disable iff (!rstN_q)
      moving && dstWrap |=> dstPtr_q == 16'h0000)
      else $error("destination index did not wrap at buffer end");

   cell_step_a: assert property (@(posedge clk) disable iff (!rstN_q)
      moving && !detect && !cellEnd |=>
         cellCnt_q == $past(cellCnt_q) + 16'h0001)
      else $error("progress did not advance by one");

   trig_start_a: assert property (@(posedge clk) disable iff (!rstN_q)
      state_q == ST_IDLE && cellTrig && enable_q |=> busReq)
      else $error("accepted trigger did not start a cell");

   trig_drop_a: assert property (@(posedge clk) disable iff (!rstN_q)
      state_q == ST_IDLE && !(cellTrig && enable_q) |=> !busReq)
      else $error("cell started without an accepted trigger");

   cell_pulse_a: assert property (@(posedge clk) disable iff (!rstN_q)
      cellEnd && !detect |=> cellDone && !xferDone)
      else $error("cell end not flagged");

   rst_clear_a: assert property (@(posedge clk)
      !rstN_q |-> srcPtr_q == 16'h0000 && dstPtr_q == 16'h0000
         && cellCnt_q == 16'h0000 && match_q == 16'h0000)
      else $error("pointer or pattern bits not cleared in reset");
endmodule

// ### sim/dcpt_bus_target.sv
// partner model: memory or peripheral target that answers byte requests
`timescale 1ns/1ps
module dcpt_bus_target (
   input  wire logic       clk,
   input  wire logic       busReq,
   input  wire logic       stall,
   input  wire logic [7:0] byteIn,
   output logic            busAck,
   output logic [7:0]      busData
);
   logic [7:0] lastQ = 8'h00;
   // a byte moves in any cycle where a request meets a target that is ready
   assign busAck  = busReq & ~stall;
   // idle data lines show the inverse of the last byte, never a stale copy
   assign busData = busAck ? byteIn : ~lastQ;
   always_ff @(posedge clk) begin
      if (busAck) begin
         lastQ <= byteIn;
      end
   end
endmodule

// ### sim/tb_top.sv
// self-checking bench for the channel progress tracking block
`timescale 1ns/1ps
module tb_top;
   import dcpt_pkg::*;
   logic clk, reset_n, psel, penable, pwrite, pready, pslverr, cellTrig;
   logic busReq, busAck, cellDone, xferDone, stall, rnd, trk, eC, eX;
   logic [7:0]  paddr, busData, byteIn;
   logic [31:0] pwdata, prdata, lf;
   logic [15:0] srcIndex, dstIndex, mMatch;
   int n_mismatch, checked, cyc, i, sLen, dLen, cSize, mSrc, mDst, mProg;
   int patOn;
   dcpt_channel u_dcpt_channel (.clk(clk), .reset_n(reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cellTrig(cellTrig), .busReq(busReq), .busAck(busAck),
      .busData(busData), .srcIndex(srcIndex), .dstIndex(dstIndex),
      .cellDone(cellDone), .xferDone(xferDone));
   dcpt_bus_target u_dcpt_bus_target (.clk(clk), .busReq(busReq),
      .stall(stall), .byteIn(byteIn), .busAck(busAck), .busData(busData));
   initial clk = 1'b0;
   always #50 clk = ~clk;
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic int span(input int n);
      return (n == 0) ? 65536 : n;
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop;
      if (n_mismatch == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // one apb transfer; the request is held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x,
                     input logic xe);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r, x);
      chk({31'h0, e}, {31'h0, xe});
   endtask
   task automatic pulse;
      cellTrig <= 1'b1;
      @(posedge clk);
      cellTrig <= 1'b0;
   endtask
   task automatic waitDone;
      do @(posedge clk); while (cellDone !== 1'b1 && xferDone !== 1'b1);
   endtask
   // random bytes and random target stalls; a stall bounds the target rate
   always @(posedge clk) begin
      lf <= lfsr(lf);
      byteIn <= lf[7:0];
      if (rnd) stall <= lf[9];
      cyc++;
      if (cyc == 40000) begin
         n_mismatch++;
         report_and_stop();
      end
   end
   // reference model: indices, progress and end pulses per moved byte
   always @(posedge clk) if (trk) begin
      chk({16'h0, srcIndex}, mSrc);
      chk({16'h0, dstIndex}, mDst);
      chk({30'h0, cellDone, xferDone}, {30'h0, eC, eX});
      eC = 1'b0;
      eX = 1'b0;
      if (busReq === 1'b1 && busAck === 1'b1) begin
         mDst = (mDst + 1 == span(dLen)) ? 0 : mDst + 1;
         if (patOn == 1 && busData == mMatch[7:0]) begin
            mSrc = 0;
            mProg = 0;
            eX = 1'b1;
         end else begin
            mSrc = (mSrc + 1 == span(sLen)) ? 0 : mSrc + 1;
            mProg++;
            if (mProg == span(cSize)) begin
               mProg = 0;
               eC = 1'b1;
            end
         end
      end
   end
   initial begin
      reset_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 8'h00; pwdata = 32'h0; cellTrig = 1'b0; stall = 1'b1;
      rnd = 1'b0; trk = 1'b0; eC = 1'b0; eX = 1'b0; lf = 32'h005B2F65;
      byteIn = 8'h00; mSrc = 0; mDst = 0; mProg = 0; patOn = 0;
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      for (i = 0; i < NUM_REGS; i++) rd(8'(i * 4), 32'h0, 1'b0);
      rd(8'h20, 32'h0, 1'b1);
      rd(8'h02, 32'h0, 1'b1);
      sLen = 5; dLen = 7; cSize = 3; mMatch = 16'hC3AA;
      wr(OFS_SRC_LEN, 32'hDEAD0005);
      wr(OFS_DST_LEN, 32'h00000007);
      wr(OFS_CELL_SIZE, 32'hBEEF0003);
      wr(OFS_MATCH, 32'h5A5AC3AA);
      wr(OFS_SRC_PTR, 32'h0000FFFF);
      rd(OFS_CELL_SIZE, 32'h3, 1'b0);
      rd(OFS_MATCH, 32'hC3AA, 1'b0);
      rd(OFS_SRC_PTR, 32'h0, 1'b0);
      trk = 1'b1;
      wr(OFS_CTRL, 32'h1);
      // hold the target so progress can be read part way through a cell
      pulse();
      stall <= 1'b0;
      @(posedge clk);
      stall <= 1'b1;
      rd(OFS_CELL_PROG, 32'h1, 1'b0);
      rnd = 1'b1;
      waitDone();
      for (i = 0; i < 3; i++) begin
         pulse();
         waitDone();
         rd(OFS_CELL_PROG, 32'h0, 1'b0);
      end
      rd(OFS_SRC_PTR, 32'(mSrc), 1'b0);
      rd(OFS_DST_PTR, 32'(mDst), 1'b0);
      cSize = 0;
      wr(OFS_CELL_SIZE, 32'h0);
      patOn = 1;
      wr(OFS_CTRL, 32'h3);
      pulse();
      waitDone();
      rd(OFS_CTRL, 32'h2, 1'b0);
      chk({31'h0, busReq}, 32'h0);
      rd(OFS_CELL_PROG, 32'h0, 1'b0);
      rd(OFS_SRC_PTR, 32'h0, 1'b0);
      rd(OFS_DST_PTR, 32'(mDst), 1'b0);
      report_and_stop();
   end
endmodule
